// ==== core/ics_pkg.sv ====
package ics_pkg;

  // Register byte offsets on the bus
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  OFS_CTRL    = 6'h00;
  localparam logic [5:0]  OFS_HYST    = 6'h04;
  localparam logic [5:0]  OFS_IN_MAX  = 6'h08;
  localparam logic [5:0]  OFS_NEU_MAX = 6'h0C;
  localparam logic [5:0]  OFS_NEU_MIN = 6'h10;
  localparam logic [5:0]  OFS_IN_MIN  = 6'h14;
  localparam logic [5:0]  OFS_TGT_MAX = 6'h18;
  localparam logic [5:0]  OFS_TGT_MIN = 6'h1C;
  localparam logic [5:0]  OFS_AVG     = 6'h20;
  localparam logic [5:0]  OFS_HYS     = 6'h24;
  localparam logic [5:0]  OFS_RESULT  = 6'h28;
  localparam logic [5:0]  OFS_STATUS  = 6'h2C;

  // Control and status bit positions
  localparam int unsigned CTRL_AVG_EN = 0;
  localparam int unsigned CTRL_INVERT = 1;
  localparam int unsigned CTRL_DEG_LO = 2;
  localparam int unsigned CTRL_SRC_RC = 4;
  localparam int unsigned CTRL_VEL    = 5;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_LOST   = 1;

  // Curve degree codes
  localparam logic [1:0] DEG_QUAD = 2'h2;
  localparam logic [1:0] DEG_CUBE = 2'h3;

  // Sample and scaler limits
  localparam logic [15:0] HYS_MIN_STEP  = 16'h0002;
  localparam logic [11:0] IN_MAX_CODE   = 12'hFFF;
  localparam logic [15:0] PW_LOST       = 16'hFFFF;

  // Shift amounts of the averaging and reduction stages
  localparam int unsigned AVG_SH_ANA     = 3;
  localparam int unsigned AVG_SH_RC      = 2;
  localparam int unsigned RAW_SH_ANA     = 3;
  localparam int unsigned RED_SH_ANA_AVG = 3;
  localparam int unsigned RED_SH_ANA_RAW = 1;
  localparam int unsigned RED_SH_RC      = 3;

  // Pipeline states, one-hot
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_HDEC  = 5'h02,
    S_HWAIT = 5'h04,
    S_SCALE = 5'h08,
    S_SWAIT = 5'h10
  } ics_state_e;

  // Software configuration
  typedef struct packed {
    logic        avg_en;
    logic        invert;
    logic [1:0]  degree;
    logic        src_rc;
    logic        vel;
    logic [15:0] hyst_step;
    logic [11:0] in_max;
    logic [11:0] neu_max;
    logic [11:0] neu_min;
    logic [11:0] in_min;
    logic [31:0] tgt_max;
    logic [31:0] tgt_min;
  } ics_cfg_s;

  // Scaled result toward the motion planner
  typedef struct packed {
    logic        is_velocity;
    logic [31:0] value;
  } ics_target_s;

  localparam ics_cfg_s CFG_RST = '{
    avg_en: 1'b1, invert: 1'b0, degree: 2'h1, src_rc: 1'b0, vel: 1'b0,
    hyst_step: 16'h0000, in_max: 12'hB90, neu_max: 12'h930,
    neu_min: 12'h8E5, in_min: 12'h698,
    tgt_max: 32'h0000_00C8, tgt_min: 32'hFFFF_FF38
  };

endpackage

// ==== core/ics_udiv.sv ====
`timescale 1ns/1ps
`default_nettype none
module ics_udiv import ics_pkg::*; #(
  parameter int unsigned NW = 16,
  parameter int unsigned DW = 16
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quo
);
  localparam int unsigned CW = $clog2(NW + 1);

  // Refuse shapes the shifter cannot serve
  if (NW < 2 || DW < 1) begin : g_bad
    $error("ics_udiv needs NW >= 2 and DW >= 1");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
    logic [DW-1:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
  } ics_div_s;

  ics_div_s    st;
  ics_div_s    next_st;
  logic [DW:0] trial;

  // Restoring division, one quotient bit per clock, truncating
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem, st.quo[NW-1]};
    if (st.busy) begin
      if (trial >= {1'b0, st.den}) begin
        next_st.rem = DW'(trial - {1'b0, st.den});
        next_st.quo = {st.quo[NW-2:0], 1'b1};
      end else begin
        next_st.rem = trial[DW-1:0];
        next_st.quo = {st.quo[NW-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - CW'(1);
      if (st.cnt == CW'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end else if (start) begin
      next_st.busy = 1'b1;
      next_st.cnt = CW'(NW);
      next_st.rem = '0;
      next_st.quo = num;
      next_st.den = den;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;
  assign quo  = st.quo;

  chk_div_finish: assert property (
    @(posedge mclk) disable iff (!rst_n)
    done |-> !busy && $past(busy) && $past(st.cnt) == CW'(1))
    else $error("quotient ready without a finished division");

endmodule
`default_nettype wire

// ==== core/ics_input_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module ics_input_scaler import ics_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  output logic             sample_ready,
  output logic             target_valid,
  output ics_target_s      target,
  output logic             signal_lost
);
  localparam int unsigned PW = 36;
  localparam int unsigned QW = 67;

  typedef struct packed {
    ics_cfg_s    cfg;
    logic [15:0] h0;
    logic [15:0] h1;
    logic [15:0] h2;
    logic [15:0] avg;
    logic [15:0] hys;
    logic        hys_init;
    logic        h_up;
    ics_state_e  fsm;
    logic        lost;
    logic        ack;
    logic [31:0] rdata;
    ics_target_s tgt;
    logic        tvalid;
    logic        neg;
    logic        hstart;
    logic [15:0] hnum;
    logic        sstart;
    logic [QW-1:0] snum;
    logic [PW-1:0] sden;
  } ics_core_s;

  ics_core_s     st;
  ics_core_s     next_st;
  logic [17:0]   sum4;
  logic [15:0]   red;
  logic [11:0]   xin;
  logic [31:0]   thi;
  logic [31:0]   tlo;
  logic          up;
  logic [11:0]   dnum;
  logic [11:0]   dden;
  logic [31:0]   tsel;
  logic [30:0]   mag;
  logic [PW-1:0] pnum;
  logic [PW-1:0] pden;
  logic [31:0]   hprod;
  logic [31:0]   wv;
  logic [31:0]   rd_word;
  logic [15:0]   hq;
  logic          hdone;
  logic [QW-1:0] sq;
  logic          sdone;

  // Byte-lane merge for register writes
  function automatic logic [31:0] ics_wmerge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Fractional distance raised to the curve degree
  function automatic logic [PW-1:0] ics_pow(input logic [11:0] b,
                                            input logic [1:0]  deg);
    logic [PW-1:0] w;
    w = {24'h000000, b};
    case (deg)
      DEG_QUAD: ics_pow = w * w;
      DEG_CUBE: ics_pow = w * w * w;
      default:  ics_pow = w;
    endcase
  endfunction

  // Stage arithmetic shared by the pipeline states
  always_comb begin
    sum4 = {2'h0, sample_data} + {2'h0, st.h0} + {2'h0, st.h1} + {2'h0, st.h2};
    if (st.cfg.src_rc) begin
      red = st.hys >> RED_SH_RC;
    end else if (st.cfg.avg_en) begin
      red = st.hys >> RED_SH_ANA_AVG;
    end else begin
      red = st.hys >> RED_SH_ANA_RAW;
    end
    xin = (red > {4'h0, IN_MAX_CODE}) ? IN_MAX_CODE : red[11:0];
    thi = st.cfg.invert ? st.cfg.tgt_min : st.cfg.tgt_max;
    tlo = st.cfg.invert ? st.cfg.tgt_max : st.cfg.tgt_min;
    up = xin > st.cfg.neu_max;
    dnum = up ? xin - st.cfg.neu_max : st.cfg.neu_min - xin;
    dden = up ? st.cfg.in_max - st.cfg.neu_max : st.cfg.neu_min - st.cfg.in_min;
    tsel = up ? thi : tlo;
    // Target minimum never reaches -2^31, so the magnitude fits
    mag = tsel[31] ? 31'(-tsel) : tsel[30:0];
    pnum = ics_pow(dnum, st.cfg.degree);
    pden = ics_pow(dden, st.cfg.degree);
    hprod = {16'h0000, hq} * {16'h0000, st.cfg.hyst_step};
  end

  // Register read mux
  always_comb begin
    case (wb_adr_i)
      OFS_CTRL:    rd_word = {26'h0, st.cfg.vel, st.cfg.src_rc, st.cfg.degree,
                              st.cfg.invert, st.cfg.avg_en};
      OFS_HYST:    rd_word = {16'h0000, st.cfg.hyst_step};
      OFS_IN_MAX:  rd_word = {20'h00000, st.cfg.in_max};
      OFS_NEU_MAX: rd_word = {20'h00000, st.cfg.neu_max};
      OFS_NEU_MIN: rd_word = {20'h00000, st.cfg.neu_min};
      OFS_IN_MIN:  rd_word = {20'h00000, st.cfg.in_min};
      OFS_TGT_MAX: rd_word = st.cfg.tgt_max;
      OFS_TGT_MIN: rd_word = st.cfg.tgt_min;
      OFS_AVG:     rd_word = {16'h0000, st.avg};
      OFS_HYS:     rd_word = {16'h0000, st.hys};
      OFS_RESULT:  rd_word = st.tgt.value;
      OFS_STATUS:  rd_word = {30'h0, st.lost, st.fsm != S_IDLE};
      default:     rd_word = 32'h0000_0000;
    endcase
    wv = ics_wmerge(rd_word, wb_dat_i, wb_sel_i);
  end

  // Next state: bus slave and conditioning pipeline
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.tvalid = 1'b0;
    next_st.hstart = 1'b0;
    next_st.sstart = 1'b0;
    // Classic slave, answers one cycle after the strobe
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = rd_word;
      if (wb_we_i) begin
        case (wb_adr_i)
          OFS_CTRL: begin
            next_st.cfg.avg_en = wv[CTRL_AVG_EN];
            next_st.cfg.invert = wv[CTRL_INVERT];
            next_st.cfg.degree = wv[CTRL_DEG_LO +: 2];
            next_st.cfg.src_rc = wv[CTRL_SRC_RC];
            next_st.cfg.vel = wv[CTRL_VEL];
          end
          OFS_HYST:    next_st.cfg.hyst_step = wv[15:0];
          OFS_IN_MAX:  next_st.cfg.in_max = wv[11:0];
          OFS_NEU_MAX: next_st.cfg.neu_max = wv[11:0];
          OFS_NEU_MIN: next_st.cfg.neu_min = wv[11:0];
          OFS_IN_MIN:  next_st.cfg.in_min = wv[11:0];
          OFS_TGT_MAX: next_st.cfg.tgt_max = wv;
          OFS_TGT_MIN: next_st.cfg.tgt_min = wv;
          default: ;
        endcase
      end
    end
    case (st.fsm)
      S_IDLE: begin
        if (sample_valid) begin
          if (st.cfg.src_rc && sample_data == PW_LOST) begin
            next_st.lost = 1'b1;
          end else begin
            next_st.lost = 1'b0;
            next_st.h2 = st.h1;
            next_st.h1 = st.h0;
            next_st.h0 = sample_data;
            // Analog samples arrive as eightfold sums, 16 bits wide
            if (st.cfg.avg_en) begin
              next_st.avg = st.cfg.src_rc ? 16'(sum4 >> AVG_SH_RC)
                                          : 16'(sum4 >> AVG_SH_ANA);
            end else begin
              next_st.avg = st.cfg.src_rc ? sample_data
                                          : sample_data >> RAW_SH_ANA;
            end
            next_st.fsm = S_HDEC;
          end
        end
      end
      S_HDEC: begin
        if (st.cfg.hyst_step < HYS_MIN_STEP) begin
          next_st.hys = st.avg;
          next_st.hys_init = 1'b0;
          next_st.fsm = S_SCALE;
        end else if (!st.hys_init) begin
          next_st.hys = '0;
          next_st.h_up = 1'b1;
          next_st.hnum = st.avg;
          next_st.hstart = 1'b1;
          next_st.fsm = S_HWAIT;
        end else if (17'(st.avg) >= 17'(st.hys) + 17'(st.cfg.hyst_step)) begin
          next_st.h_up = 1'b1;
          next_st.hnum = st.avg - st.hys;
          next_st.hstart = 1'b1;
          next_st.fsm = S_HWAIT;
        end else if (17'(st.avg) + 17'(st.cfg.hyst_step) <= 17'(st.hys)) begin
          next_st.h_up = 1'b0;
          next_st.hnum = st.hys - st.avg;
          next_st.hstart = 1'b1;
          next_st.fsm = S_HWAIT;
        end else begin
          next_st.fsm = S_SCALE;
        end
      end
      S_HWAIT: begin
        // Whole steps only, so the move rounds toward the held value
        if (hdone) begin
          next_st.hys = st.h_up ? st.hys + hprod[15:0] : st.hys - hprod[15:0];
          next_st.hys_init = 1'b1;
          next_st.fsm = S_SCALE;
        end
      end
      S_SCALE: begin
        if (xin > st.cfg.in_max) begin
          next_st.tgt.value = thi;
          next_st.tvalid = 1'b1;
          next_st.fsm = S_IDLE;
        end else if (xin < st.cfg.in_min) begin
          next_st.tgt.value = tlo;
          next_st.tvalid = 1'b1;
          next_st.fsm = S_IDLE;
        end else if (xin >= st.cfg.neu_min && xin <= st.cfg.neu_max) begin
          next_st.tgt.value = '0;
          next_st.tvalid = 1'b1;
          next_st.fsm = S_IDLE;
        end else begin
          next_st.neg = tsel[31];
          next_st.snum = {36'h0, mag} * {31'h0, pnum};
          next_st.sden = pden;
          next_st.sstart = 1'b1;
          next_st.fsm = S_SWAIT;
        end
      end
      S_SWAIT: begin
        if (sdone) begin
          next_st.tgt.value = st.neg ? 32'(-{1'b0, sq[30:0]}) : {1'b0, sq[30:0]};
          next_st.tvalid = 1'b1;
          next_st.fsm = S_IDLE;
        end
      end
      default: next_st.fsm = S_IDLE;
    endcase
    // Mode tag moves only with a new result, so the target holds between strobes
    if (next_st.tvalid) begin
      next_st.tgt.is_velocity = st.cfg.vel;
    end
  end

  // State register, cleared history and defaults on reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.cfg <= CFG_RST;
      st.fsm <= S_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Step count for the hysteresis move
  ics_udiv #(.NW(16), .DW(16)) u_hdiv (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (st.hstart),
    .num   (st.hnum),
    .den   (st.cfg.hyst_step),
    .busy  (),
    .done  (hdone),
    .quo   (hq)
  );

  // Curve interpolation divider
  ics_udiv #(.NW(QW), .DW(PW)) u_sdiv (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (st.sstart),
    .num   (st.snum),
    .den   (st.sden),
    .busy  (),
    .done  (sdone),
    .quo   (sq)
  );

  assign wb_dat_o     = st.rdata;
  assign wb_ack_o     = st.ack;
  assign sample_ready = st.fsm == S_IDLE;
  assign target_valid = st.tvalid;
  assign target       = st.tgt;
  assign signal_lost  = st.lost;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_avg_running: assert property (
    sample_valid && sample_ready && st.cfg.avg_en && !st.cfg.src_rc |=>
    st.avg == 16'((18'($past(sample_data)) + $past(st.h0) + $past(st.h1)
                  + $past(st.h2)) >> AVG_SH_ANA))
    else $error("averaged value is not the mean of four samples");

  chk_avg_bypass: assert property (
    sample_valid && sample_ready && !st.cfg.avg_en && st.cfg.src_rc
    && sample_data != PW_LOST |=> st.avg == $past(sample_data))
    else $error("raw pulse width not loaded directly");

  chk_lost_skip: assert property (
    sample_valid && sample_ready && st.cfg.src_rc && sample_data == PW_LOST
    |=> signal_lost && sample_ready && $stable(st.avg))
    else $error("lost pulse width entered the pipeline");

  chk_hys_copy: assert property (
    st.fsm == S_SCALE && st.cfg.hyst_step < HYS_MIN_STEP |-> st.hys == st.avg)
    else $error("inactive hysteresis changed the value");

  chk_hys_grid: assert property (
    st.fsm == S_SCALE && st.cfg.hyst_step >= HYS_MIN_STEP
    |-> st.hys % st.cfg.hyst_step == 0)
    else $error("hysteresis result not a multiple of the step");

  chk_reduce_raw: assert property (
    st.fsm == S_SCALE && !st.cfg.src_rc && !st.cfg.avg_en && st.hys[15:13] == 3'h0
    |-> xin == 12'(st.hys >> RED_SH_ANA_RAW))
    else $error("raw analog reduction is not a halving");

  chk_clip_high: assert property (
    st.fsm == S_SCALE && xin > st.cfg.in_max |=> target_valid
    && target.value == $past(st.cfg.invert ? st.cfg.tgt_min : st.cfg.tgt_max))
    else $error("input above maximum did not give the upper target");

  chk_clip_low: assert property (
    st.fsm == S_SCALE && xin < st.cfg.in_min && xin <= st.cfg.in_max |=> target_valid
    && target.value == $past(st.cfg.invert ? st.cfg.tgt_max : st.cfg.tgt_min))
    else $error("input below minimum did not give the lower target");

  chk_neutral_zero: assert property (
    st.fsm == S_SCALE && xin >= st.cfg.in_min && xin <= st.cfg.in_max
    && xin >= st.cfg.neu_min && xin <= st.cfg.neu_max
    |=> target_valid && target.value == 32'h0000_0000)
    else $error("neutral input did not give zero");

  chk_out_hold: assert property (
    !target_valid |-> $stable(target))
    else $error("target changed without a valid strobe");

endmodule
`default_nettype wire

// ==== bench/ics_sample_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module ics_sample_src import ics_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sample_ready,
  input  wire logic        send,
  input  wire logic [15:0] send_data,
  input  wire logic [1:0]  send_lag,
  output logic             sample_valid,
  output logic [15:0]      sample_data,
  output logic             taken
);
  logic       send_q;
  logic       pend;
  logic [1:0] lag;

  // One sample per rising send, after a short lag, held until the block takes it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sample_valid <= 1'b0;
      sample_data  <= 16'h0000;
      taken        <= 1'b0;
      send_q       <= 1'b0;
      pend         <= 1'b0;
      lag          <= 2'h0;
    end else begin
      send_q <= send;
      taken  <= 1'b0;
      if (sample_valid && sample_ready) begin
        sample_valid <= 1'b0;
        sample_data  <= ~sample_data; // Released data no longer shows the sample
        taken        <= 1'b1;
      end else if (send && !send_q) begin
        pend <= 1'b1;
        lag  <= send_lag;
      end else if (pend && lag == 2'h0) begin
        pend         <= 1'b0;
        sample_valid <= 1'b1;
        sample_data  <= send_data; // Analog sums or pulse widths as given
      end else if (pend) begin
        lag <= lag - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/ics_input_scaler_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ics_input_scaler_tb import ics_pkg::*;;
  logic              mclk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0, send = 1'b0;
  logic [5:0]        wb_adr_i = 6'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rd, held, tmax, tmin, seed;
  logic              wb_ack_o, sample_valid, sample_ready, target_valid, signal_lost, taken;
  logic [15:0]       sample_data, send_data = 16'h0, step;
  logic [1:0]        send_lag = 2'h0;
  logic [5:0]        ctl;
  logic [3:0][15:0]  hist;
  logic              hinit;
  ics_target_s       target;
  logic [32:0]       last_t;
  int                failures = 0, compares = 0, cycles = 0;
  localparam logic [5:0]  RA [10] = '{OFS_CTRL, OFS_HYST, OFS_IN_MAX, OFS_NEU_MAX,
    OFS_NEU_MIN, OFS_IN_MIN, OFS_TGT_MAX, OFS_TGT_MIN, OFS_STATUS, 6'h30};
  localparam logic [31:0] RV [10] = '{32'h5, 32'h0, 32'hB90, 32'h930, 32'h8E5, 32'h698,
    32'hC8, 32'hFFFF_FF38, 32'h0, 32'h0};
  localparam logic [5:0]  CTL [8] = '{6'h05, 6'h09, 6'h0F, 6'h00, 6'h25, 6'h15, 6'h14, 6'h1E};
  localparam logic [15:0] STP [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h64, 16'h0, 16'h1, 16'h25};
  localparam logic [15:0] CRN [10] = '{16'h5C80, 16'h5C88, 16'h4980, 16'h4988, 16'h4728,
    16'h4720, 16'h34C0, 16'h34B8, 16'hFFFF, 16'h0000};

  ics_input_scaler dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready), .target_valid(target_valid),
    .target(target), .signal_lost(signal_lost));
  ics_sample_src src (.mclk(mclk), .rst_n(rst_n), .sample_ready(sample_ready), .send(send),
    .send_data(send_data), .send_lag(send_lag), .sample_valid(sample_valid),
    .sample_data(sample_data), .taken(taken));

  // Clock and hang limit
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Piecewise curve with truncation toward zero
  function automatic logic [31:0] scale(input logic [11:0] x);
    logic signed [32:0] hi, lo, t;
    logic [127:0]       num, den, d, dd;
    hi = $signed(ctl[1] ? tmin : tmax);
    lo = $signed(ctl[1] ? tmax : tmin);
    if (x > CFG_RST.in_max) return hi[31:0];
    if (x < CFG_RST.in_min) return lo[31:0];
    if (x <= CFG_RST.neu_max && x >= CFG_RST.neu_min) return 32'h0;
    t = (x > CFG_RST.neu_max) ? hi : lo;
    d = (x > CFG_RST.neu_max) ? 128'(x - CFG_RST.neu_max) : 128'(CFG_RST.neu_min - x);
    dd = (x > CFG_RST.neu_max) ? 128'(CFG_RST.in_max - CFG_RST.neu_max)
                               : 128'(CFG_RST.neu_min - CFG_RST.in_min);
    num = 128'(t < 0 ? -t : t);
    den = 128'h1;
    repeat ((ctl[3:2] == 2'h0) ? 1 : int'(ctl[3:2])) begin
      num = num * d;
      den = den * dd;
    end
    num = num / den;
    return (t < 0) ? -num[31:0] : num[31:0];
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // One classic Wishbone cycle, read data left in rd
  task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    hist = '0;
    hinit = 1'b0;
    held = 32'h0;
    last_t = 33'h0;
  endtask

  // Reference pipeline for one accepted sample
  task automatic model(input logic [15:0] s, output logic [31:0] ea, output logic [31:0] eh);
    logic [31:0] sum;
    hist = {hist[2:0], s};
    sum = 32'(hist[0]) + 32'(hist[1]) + 32'(hist[2]) + 32'(hist[3]);
    if (ctl[0]) ea = ctl[4] ? sum >> 2 : sum >> 3;
    else ea = ctl[4] ? 32'(s) : 32'(s >> 3);
    if (step < HYS_MIN_STEP) hinit = 1'b0;
    else if (!hinit) begin
      held = (ea / step) * step;
      hinit = 1'b1;
    end else if (ea >= held + step) held = held + ((ea - held) / step) * step;
    else if (ea + step <= held) held = held - ((held - ea) / step) * step;
    eh = (step < HYS_MIN_STEP) ? ea : held;
  endtask

  // Feed one sample through the producer and compare everything it should change
  task automatic put(input logic [15:0] s);
    logic [31:0] ea, eh, et;
    int          n;
    n = 0;
    check(target, last_t, "target held");
    @(posedge mclk);
    send_data <= s;
    send_lag <= seed[1:0];
    send <= 1'b1;
    do @(negedge mclk); while (taken !== 1'b1);
    @(posedge mclk);
    send <= 1'b0;
    if (ctl[4] && s == PW_LOST) begin
      repeat (100) begin
        @(negedge mclk);
        n += int'(target_valid === 1'b1);
      end
      check(n, 0, "output on lost sample");
      check(signal_lost, 1'b1, "lost flag");
      check(sample_ready, 1'b1, "ready after lost sample");
    end else begin
      model(s, ea, eh);
      et = scale((eh >> ((!ctl[4] && !ctl[0]) ? 1 : 3)) > 32'd4095 ? 12'hFFF
                 : 12'(eh >> ((!ctl[4] && !ctl[0]) ? 1 : 3)));
      do @(negedge mclk); while (target_valid !== 1'b1);
      last_t = {ctl[5], et};
      check(target, last_t, "target");
      check(signal_lost, 1'b0, "lost flag clear");
      check(sample_ready, 1'b1, "ready with result");
      wb(1'b0, OFS_AVG, 32'h0, 4'hF);
      check(rd, ea, "averaged value");
      wb(1'b0, OFS_HYS, 32'h0, 4'hF);
      check(rd, eh, "hysteresis value");
      wb(1'b0, OFS_RESULT, 32'h0, 4'hF);
      check(rd, et, "result register");
    end
  endtask

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Register defaults, read-only and unmapped places, then eight control modes with corners and randoms
  initial begin
    seed = 32'he0b2;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, RA[i], 32'h0, 4'hF);
      check(rd, RV[i], "reset value");
    end
    wb(1'b1, OFS_RESULT, 32'h1234, 4'hF);
    wb(1'b0, OFS_RESULT, 32'h0, 4'hF);
    check(rd, 32'h0, "read-only result");
    wb(1'b1, OFS_HYST, 32'hABCD, 4'h1);
    wb(1'b0, OFS_HYST, 32'h0, 4'hF);
    check(rd, 32'hCD, "byte lane write");
    wb(1'b1, 6'h30, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 6'h30, 32'h0, 4'hF);
    check(rd, 32'h0, "unmapped place");
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      do_reset();
      ctl = CTL[c];
      step = STP[c];
      seed = lfsr(seed);
      tmax = {1'b0, seed[30:0]}; // Targets within the signed range
      seed = lfsr(seed);
      tmin = -{1'b0, seed[30:0]};
      wb(1'b1, OFS_CTRL, 32'(ctl), 4'hF);
      wb(1'b1, OFS_HYST, 32'(step), 4'hF);
      wb(1'b1, OFS_TGT_MAX, tmax, 4'hF);
      wb(1'b1, OFS_TGT_MIN, tmin, 4'hF);
      wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
      check(rd, 32'(ctl), "control readback");
      for (int k = 0; k < 22; k++) begin
        seed = lfsr(seed);
        if (k < 10) put(ctl[4] ? CRN[k] : (CRN[k] & 16'hFFC0));
        else put(ctl[4] ? 16'(2400 + seed % 30000) : (seed[15:0] & 16'hFFC0));
      end
      $display("test mode %0d done", c);
    end
    finish_test();
  end
endmodule
`default_nettype wire
